// ===== bench/apsc_core_model.sv
// Purpose: analog core and trigger source beside apsc_scan_ctrl
// Assumes: pulses outlast the pin synchroniser
// Notes:   slot_disable is changed by the bench between scans
`timescale 1ns/1ps
module apsc_core_model (
    input  wire       core_clk,
    input  wire       conv_a_sample,
    input  wire       conv_b_sample,
    output reg        conv_a_trigger_pin = 1'b0,
    output reg        conv_b_trigger_pin = 1'b0,
    output reg  [7:0] slot_disable = 8'h00
);
    integer n_a = 0;
    integer n_b = 0;
    // tally conversions asked of each converter
    always @(posedge core_clk) begin
        n_a <= n_a + conv_a_sample;
        n_b <= n_b + conv_b_sample;
    end
    // one rising edge on the b pin, held four cycles
    task pulse;
        begin
            conv_b_trigger_pin <= 1'b1;
            repeat (4) @(posedge core_clk);
            conv_b_trigger_pin <= 1'b0;
            @(posedge core_clk);
        end
    endtask
endmodule // apsc_core_model

// ===== bench/apsc_properties.sv
// Purpose: port properties of apsc_scan_ctrl
// Assumes: mode bits change only while both converters idle
// Notes:   control bits are shadowed from completed bus writes
`timescale 1ns/1ps
module apsc_chk (
    input wire        core_clk,
    input wire        srst,
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    input wire [7:0]  slot_disable,
    input wire        conv_en,
    input wire        conv_a_sample,
    input wire [2:0]  conv_a_slot,
    input wire        conv_b_sample,
    input wire [2:0]  conv_b_slot,
    input wire        conv_b_end_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire       ok = avs_write && !avs_waitrequest;
    reg  [4:0] ratio;
    reg  [6:0] cnt;
    reg        lock, par, bh, rl;
    // shadow state; rl marks an enable gap broken by reset or reload
    always @(posedge core_clk) begin
        cnt <= conv_en ? 7'h01 : cnt + 7'h01;
        rl <= srst | (ok && avs_address == 4'h0) | (rl & ~conv_en);
        if (srst) begin
            {bh, lock, par, ratio} <= 8'h40;
        end else if (ok && avs_address == 4'h0) begin
            {bh, lock, ratio} <= {avs_writedata[14], avs_writedata[5:0]};
        end else if (ok && avs_address == 4'h4) begin
            par <= avs_writedata[0];
        end
    end
    sequence s_ack;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    AST_ACK: assert property ($rose(avs_read | avs_write) |-> s_ack)
        else $error("bus answer late");
    AST_DIV: assert property (conv_en && !rl |-> cnt == {1'b0, ratio, 1'b0} + 7'h02)
        else $error("enable spacing wrong");
    AST_EN1: assert property (conv_en |=> !conv_en)
        else $error("enable too long");
    AST_BSLOT: assert property (conv_b_sample |-> conv_b_slot[2] && !slot_disable[conv_b_slot])
        else $error("bad b slot");
    AST_ASLOT: assert property (conv_a_sample && par |-> !conv_a_slot[2] && !slot_disable[conv_a_slot])
        else $error("bad a slot");
    AST_PAIR: assert property (par && lock |-> conv_a_sample == conv_b_sample)
        else $error("unpaired sample");
    AST_SEQ: assert property (!par |-> !conv_b_sample)
        else $error("b active in sequential");
    AST_HALT: assert property (par && !lock && bh && $past(bh) |-> !conv_b_sample)
        else $error("b sample while halted");
    AST_IRQ: assert property (conv_b_end_irq |=> !conv_b_end_irq)
        else $error("b irq too long");
    AST_PACE: assert property (conv_b_sample |-> $past(conv_en))
        else $error("b sample off pace");
endmodule // apsc_chk
bind apsc_scan_ctrl apsc_chk u_chk (.*);

// ===== bench/testbench.sv
// Purpose: self-checking bench for apsc_scan_ctrl
// Assumes: 40 MHz clock; mode writes only while idle
// Notes:   ratio 3 keeps the conversion clock at 5 MHz
`timescale 1ns/1ps
module testbench;
    reg         core_clk = 1'b0;
    reg         srst = 1'b1;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg  [3:0]  avs_byteenable = 4'h3;
    wire [31:0] avs_readdata;
    wire [7:0]  slot_disable;
    wire [2:0]  conv_a_slot, conv_b_slot;
    wire        avs_waitrequest, avs_response_err, conv_en, conv_a_sample, conv_b_sample;
    wire        conv_a_end_irq, conv_b_end_irq, conv_a_trigger_pin, conv_b_trigger_pin;
    reg  [31:0] q;
    reg         e;
    integer     n_errors = 0, n_checks = 0, n_ai = 0, n_bi = 0, k, i, b0;
    reg  [4:0]  row_r [0:3] = '{5'h03, 5'h04, 5'h07, 5'h1f};
    integer     row_d [0:3] = '{8, 10, 16, 64};
    apsc_scan_ctrl u_dut (.*);
    apsc_core_model u_core (.*);
    always #12.5 core_clk = ~core_clk;
    // count end-of-scan pulses
    always @(posedge core_clk) begin
        n_ai <= n_ai + conv_a_end_irq;
        n_bi <= n_bi + conv_b_end_irq;
    end
    task chk(input logic [31:0] s, input logic [31:0] x);
        begin
            n_checks = n_checks + 1;
            if (s !== x) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, s, x);
            end
        end
    endtask
    // one request held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        begin
            avs_address <= a;
            avs_writedata <= {16'h0000, d};
            avs_write <= w;
            avs_read <= ~w;
            k = 0;
            do begin
                @(posedge core_clk);
                k = k + 1;
            end while (avs_waitrequest !== 1'b0 && k < 40);
            if (k >= 40) n_errors = n_errors + 1;
            q = avs_readdata;
            e = avs_response_err;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge core_clk);
        end
    endtask
    task wait_en;
        begin
            k = 0;
            do begin
                @(posedge core_clk);
                k = k + 1;
            end while (conv_en !== 1'b1 && k < 200);
        end
    endtask
    // bounded wait for end-of-scan counts
    task wait_irq(input integer na, input integer nb);
        begin
            k = 0;
            while ((n_ai < na || n_bi < nb) && k < 400) begin
                @(posedge core_clk);
                k = k + 1;
            end
            if (k >= 400) n_errors = n_errors + 1;
            repeat (2) @(posedge core_clk);
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_errors);
            if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        #250000;
        n_errors = n_errors + 1;
        wrap_up;
    end
    initial begin
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        bus(0, 4'h0, 16'h0000);
        chk(q[15:0], 16'h0020);
        chk(conv_b_slot, 3'h4);
        for (i = 0; i < 4; i = i + 1) begin
            bus(1, 4'h0, {11'h001, row_r[i]});
            wait_en;
            wait_en;
            chk(k, row_d[i]);
        end
        $display("test divider done");
        bus(1, 4'h4, 16'h0001);
        bus(1, 4'h0, 16'h2803);
        bus(1, 4'h0, 16'h2803);
        bus(0, 4'h8, 16'h0000);
        chk(q[1:0], 2'h2);
        wait_irq(0, 1);
        chk(u_core.n_b, 4);
        chk(u_core.n_a, 0);
        u_core.slot_disable <= 8'h40;
        bus(1, 4'h0, 16'h2803);
        wait_irq(0, 2);
        chk(u_core.n_b, 6);
        chk(n_bi, 2);
        u_core.slot_disable <= 8'h00;
        bus(1, 4'h4, 16'h0005);
        u_core.pulse;
        bus(0, 4'h8, 16'h0000);
        chk(q[1], 1'b0);
        bus(1, 4'h0, 16'h1803);
        u_core.pulse;
        u_core.pulse;
        wait_irq(0, 3);
        u_core.pulse;
        wait_irq(0, 4);
        chk(u_core.n_b, 14);
        bus(1, 4'h4, 16'h0001);
        bus(1, 4'h0, 16'h1803);
        u_core.pulse;
        wait_irq(0, 5);
        u_core.pulse;
        bus(0, 4'h8, 16'h0000);
        chk(q[1], 1'b0);
        bus(1, 4'h0, 16'h1803);
        u_core.pulse;
        wait_irq(0, 6);
        chk(u_core.n_b, 22);
        $display("test b scan done");
        bus(1, 4'h4, 16'h0003);
        bus(1, 4'h0, 16'h2803);
        wait_irq(0, 8);
        chk(u_core.n_b, 30);
        bus(1, 4'h0, 16'h4803);
        bus(0, 4'h8, 16'h0000);
        chk(q[1], 1'b0);
        b0 = u_core.n_b;
        bus(1, 4'h0, 16'h7803);
        u_core.pulse;
        repeat (40) @(posedge core_clk);
        chk(u_core.n_b, b0);
        $display("test halt done");
        bus(1, 4'h0, 16'h0023);
        i = n_bi;
        b0 = u_core.n_b;
        bus(1, 4'h4, 16'h2801);
        bus(0, 4'h8, 16'h0000);
        chk(q[0], 1'b1);
        wait_irq(1, 0);
        chk(u_core.n_a, 4);
        chk(u_core.n_b, b0 + 4);
        u_core.slot_disable <= 8'h04;
        bus(1, 4'h4, 16'h2801);
        wait_irq(2, 0);
        chk(u_core.n_a, 6);
        chk(u_core.n_b, b0 + 6);
        chk(n_bi, i);
        bus(1, 4'h0, 16'h2023);
        bus(0, 4'h8, 16'h0000);
        chk(q[1:0], 2'h0);
        $display("test lockstep done");
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        bus(0, 4'h0, 16'h0000);
        chk(q[15:0], 16'h0020);
        bus(0, 4'hc, 16'h0000);
        chk(e, 1'b1);
        $display("test reset again done");
        wrap_up;
    end
endmodule // testbench

// ===== logic/apsc_clk_div.v
// Purpose: conversion clock enable divider, core clock / (2*ratio+2)
// Assumes: ratio is a core-clock register; reload pulses on every control-two write with the low byte lane enabled
// Notes:   the output is a one-cycle enable, not a clock
`timescale 1ns/1ps
module apsc_clk_div (
    input  wire       core_clk,
    input  wire       srst,
    input  wire [4:0] ratio,
    input  wire       reload,
    output reg        conv_en
);

////////////////////////////////////////////////////////////////////////////////
// counter runs 0..2*ratio+1, enable fires on the last count
reg  [5:0] count;
wire [5:0] last = {ratio, 1'b1};

always @(posedge core_clk) begin
    if (srst || reload) begin
        count   <= 6'h00;
        conv_en <= 1'b0;
    end else if (count == last) begin
        count   <= 6'h00;
        conv_en <= 1'b1;
    end else begin
        count   <= count + 6'h01;
        conv_en <= 1'b0;
    end
end

endmodule // apsc_clk_div

// ===== logic/apsc_regs.vh
// Purpose: constants for the parallel scan control block
// Assumes: 40 MHz core clock, Avalon-MM byte addressing on a 32-bit bus
// Notes:   offsets are byte addresses
`ifndef APSC_REGS_VH
`define APSC_REGS_VH

`define APSC_OFF_CONVERTER_CONTROL_TWO        4'h0
`define APSC_OFF_CTRL1        4'h4
`define APSC_OFF_STATUS       4'h8

`define APSC_CONVERTER_CONTROL_TWO_RESET      16'h0020
`define APSC_CONVERTER_CONTROL_TWO_WMASK      16'h583f

`define APSC_BIT_B_HALT       14
`define APSC_BIT_B_GO         13
`define APSC_BIT_B_ARM        12
`define APSC_BIT_B_IRQEN      11
`define APSC_BIT_LOCKSTEP     5
`define APSC_DIV_HI           4

`define APSC_BIT_A_HALT       14
`define APSC_BIT_A_GO         13
`define APSC_BIT_A_ARM        12
`define APSC_BIT_A_IRQEN      11
`define APSC_SMODE_HI         2
`define APSC_CTRL1_RESET      16'h0000
`define APSC_CTRL1_WMASK      16'h5807

`define APSC_ST_A_BUSY        0
`define APSC_ST_B_BUSY        1
`define APSC_ST_A_IRQ         2
`define APSC_ST_B_IRQ         3

`define APSC_SMODE_ONCE_PAR   3'h1
`define APSC_SMODE_LOOP_PAR   3'h3
`define APSC_SMODE_TRIG_PAR   3'h5
`define APSC_SMODE_ONCE_SEQ   3'h0

`define APSC_SLOTS            3'h4

`endif

// ===== logic/apsc_scan_ctrl.v
// Contract
// - independent mode, armed: rising edge on B trigger starts a B scan
// - B trigger edges during an active B scan are ignored
// - once modes: only first trigger honoured until arm bit written to one again
// - arm clear: only go write starts B; arm set: trigger also starts
// - independent mode: B end interrupt per B scan when enabled
// - looping modes raise end interrupt after every iteration
// - lockstep: both converters scan in pairs under converter A controls only
// - lockstep: scan ends in both when either hits a disabled slot
// - lockstep: A end interrupt at completion; A busy shows parallel scan
// - lockstep clear: A and B run independently with own controls and status
// - independent: scan ends after four slots or at a disabled slot
// - independent looping: next iteration at once until own halt bit set
// - lockstep select sits at bit 5, resets to one
// - lockstep select has no effect in sequential modes
// - conversion clock is core clock over 2*ratio+2
// - B go write starts a B scan; repeats ignored while scanning
// - B halt stops B scans and blocks triggers and go writes
// - independent mode: B busy flag shows an active B scan
//
// Purpose: converter A/B parallel scan sequencing with an Avalon-MM register port
// Assumes: one slot converts per conversion-clock enable; triggers are async pins
// Notes:   sequential modes run A as one eight-slot scan; B stays idle
`timescale 1ns/1ps
`include "apsc_regs.vh"
module apsc_scan_ctrl (
    input  wire        core_clk,
    input  wire        srst,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output reg         avs_response_err,
    input  wire        conv_a_trigger_pin,
    input  wire        conv_b_trigger_pin,
    input  wire [7:0]  slot_disable,
    output wire        conv_en,
    output reg         conv_a_sample,
    output reg  [2:0]  conv_a_slot,
    output reg         conv_b_sample,
    output reg  [2:0]  conv_b_slot,
    output reg         conv_a_end_irq,
    output reg         conv_b_end_irq
);

////////////////////////////////////////////////////////////////////////////////
// register port: one wait cycle, answer on the second edge of a request
reg         ack;
reg  [15:0] converter_control_two;
reg  [15:0] converter_control_one;
wire        req = (avs_read || avs_write) && !ack;
wire        wr_hit = avs_write && ack;
wire        sel_c2 = (avs_address == `APSC_OFF_CONVERTER_CONTROL_TWO);
wire        sel_c1 = (avs_address == `APSC_OFF_CTRL1);
wire        sel_st = (avs_address == `APSC_OFF_STATUS);
wire [15:0] be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
wire [15:0] wdata = avs_writedata[15:0];

assign avs_waitrequest = (avs_read || avs_write) && !ack;

// true when a write hit lands a one on the given bit of a register
function wr_one;
    input        hit;
    input [15:0] data;
    input [15:0] mask;
    input integer pos;
    begin
        wr_one = hit && data[pos] && mask[pos];
    end
endfunction

wire c2_wr = wr_hit && sel_c2;
wire c1_wr = wr_hit && sel_c1;
wire b_go_wr  = wr_one(c2_wr, wdata, be_mask, `APSC_BIT_B_GO);
wire b_arm_wr = wr_one(c2_wr, wdata, be_mask, `APSC_BIT_B_ARM);
wire a_go_wr  = wr_one(c1_wr, wdata, be_mask, `APSC_BIT_A_GO);
wire a_arm_wr = wr_one(c1_wr, wdata, be_mask, `APSC_BIT_A_ARM);
wire div_wr   = c2_wr && avs_byteenable[0];

// go bits are write-only, stored bits keep the byte-lane masking
always @(posedge core_clk) begin
    if (srst) begin
        ack                   <= 1'b0;
        converter_control_two <= `APSC_CONVERTER_CONTROL_TWO_RESET;
        converter_control_one <= `APSC_CTRL1_RESET;
    end else begin
        ack <= req;
        if (c2_wr)
            converter_control_two <= (converter_control_two & ~(be_mask & `APSC_CONVERTER_CONTROL_TWO_WMASK))
                                   | (wdata & be_mask & `APSC_CONVERTER_CONTROL_TWO_WMASK);
        if (c1_wr)
            converter_control_one <= (converter_control_one & ~(be_mask & `APSC_CTRL1_WMASK))
                                   | (wdata & be_mask & `APSC_CTRL1_WMASK);
    end
end

////////////////////////////////////////////////////////////////////////////////
// field decode
wire [2:0] smode    = converter_control_one[`APSC_SMODE_HI:0];
wire       parallel = smode[0];
wire       looping  = (smode == `APSC_SMODE_LOOP_PAR) || (smode == 3'h2);
wire       once     = (smode == `APSC_SMODE_ONCE_PAR) || (smode == `APSC_SMODE_ONCE_SEQ);
wire       lockstep = parallel && converter_control_two[`APSC_BIT_LOCKSTEP];
wire       indep    = parallel && !converter_control_two[`APSC_BIT_LOCKSTEP];
wire       a_halt   = converter_control_one[`APSC_BIT_A_HALT];
wire       a_arm    = converter_control_one[`APSC_BIT_A_ARM];
wire       a_irqen  = converter_control_one[`APSC_BIT_A_IRQEN];
wire       b_halt   = converter_control_two[`APSC_BIT_B_HALT];
wire       b_arm    = converter_control_two[`APSC_BIT_B_ARM];
wire       b_irqen  = converter_control_two[`APSC_BIT_B_IRQEN];

apsc_clk_div u_div (
    .core_clk (core_clk),
    .srst     (srst),
    .ratio    (converter_control_two[`APSC_DIV_HI:0]),
    .reload   (div_wr),
    .conv_en  (conv_en)
);

////////////////////////////////////////////////////////////////////////////////
// trigger pins: two-flop synchronisers, edge taken from the second and third flops
reg [2:0] a_sync;
reg [2:0] b_sync;

always @(posedge core_clk) begin
    if (srst) begin
        a_sync <= 3'h0;
        b_sync <= 3'h0;
    end else begin
        a_sync <= {a_sync[1:0], conv_a_trigger_pin};
        b_sync <= {b_sync[1:0], conv_b_trigger_pin};
    end
end

wire a_edge = a_sync[1] && !a_sync[2];
wire b_edge = b_sync[1] && !b_sync[2];

////////////////////////////////////////////////////////////////////////////////
// arm latches: once modes spend the arm on the first honoured edge
reg a_armed;
reg b_armed;
reg a_busy;
reg b_busy;

wire a_trig_ok = a_arm && a_armed && a_edge;
wire b_trig_ok = b_arm && b_armed && b_edge && indep;
wire a_start   = !a_busy && !a_halt && (a_go_wr || a_trig_ok);
wire b_start   = indep && !b_busy && !b_halt && (b_go_wr || b_trig_ok);

always @(posedge core_clk) begin
    if (srst) begin
        a_armed <= 1'b1;
        b_armed <= 1'b1;
    end else begin
        // re-arm write wins over a spend in the same cycle
        if (a_arm_wr)
            a_armed <= 1'b1;
        else if (a_start && a_trig_ok && once)
            a_armed <= 1'b0;
        if (b_arm_wr)
            b_armed <= 1'b1;
        else if (b_start && b_trig_ok && once)
            b_armed <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// scan sequencers; slot counters step on each conversion enable
reg  [3:0] a_idx;
reg  [1:0] b_idx;
wire [3:0] a_len  = parallel ? {1'b0, `APSC_SLOTS} : 4'h8;
wire [2:0] a_slot = a_idx[2:0];
wire [2:0] b_slot = {1'b1, b_idx};
wire a_off  = slot_disable[a_slot];
wire b_off  = slot_disable[b_slot];
wire a_last_slot = (a_idx == a_len - 4'h1);
wire b_last_slot = (b_idx == 2'h3);
// lockstep pairs end together on any disabled slot
wire pair_stop = lockstep && (a_off || slot_disable[{1'b1, a_idx[1:0]}]);
wire a_done_dis = pair_stop || (!lockstep && a_off);
// halt gates the step so no strobe leaves in the cycle the halt lands
wire a_step = a_busy && conv_en && !a_halt;
wire b_step = b_busy && conv_en && !b_halt;
wire a_iter_end = a_step && (a_done_dis || a_last_slot);
wire b_iter_end = b_step && (b_off || b_last_slot);
wire a_again = looping && !a_halt;
wire b_again = looping && !b_halt;

always @(posedge core_clk) begin
    if (srst) begin
        a_busy <= 1'b0;
        a_idx  <= 4'h0;
    end else if (a_halt) begin
        a_busy <= 1'b0;
        a_idx  <= 4'h0;
    end else if (a_start) begin
        a_busy <= 1'b1;
        a_idx  <= 4'h0;
    end else if (a_iter_end) begin
        a_busy <= a_again;
        a_idx  <= 4'h0;
    end else if (a_step) begin
        a_idx  <= a_idx + 4'h1;
    end
end

always @(posedge core_clk) begin
    if (srst) begin
        b_busy <= 1'b0;
        b_idx  <= 2'h0;
    end else if (b_halt || !indep) begin
        b_busy <= 1'b0;
        b_idx  <= 2'h0;
    end else if (b_start) begin
        b_busy <= 1'b1;
        b_idx  <= 2'h0;
    end else if (b_iter_end) begin
        b_busy <= b_again;
        b_idx  <= 2'h0;
    end else if (b_step) begin
        b_idx  <= b_idx + 2'h1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sample strobes to the analog core; in lockstep B follows A slot for slot
always @(posedge core_clk) begin
    if (srst) begin
        conv_a_sample <= 1'b0;
        conv_a_slot   <= 3'h0;
        conv_b_sample <= 1'b0;
        conv_b_slot   <= 3'h4;
    end else begin
        conv_a_sample <= a_step && !a_done_dis;
        conv_a_slot   <= a_slot;
        if (lockstep) begin
            conv_b_sample <= a_step && !pair_stop;
            conv_b_slot   <= {1'b1, a_idx[1:0]};
        end else begin
            conv_b_sample <= b_step && !b_off;
            conv_b_slot   <= b_slot;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// end-of-scan pulses, one per finished iteration; no sticky status here
always @(posedge core_clk) begin
    if (srst) begin
        conv_a_end_irq <= 1'b0;
        conv_b_end_irq <= 1'b0;
    end else begin
        conv_a_end_irq <= a_iter_end && a_irqen;
        conv_b_end_irq <= b_iter_end && b_irqen && indep;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read mux; go bits read as zero, unmapped addresses answer with an error
always @(posedge core_clk) begin
    if (srst) begin
        avs_readdata     <= 32'h0000_0000;
        avs_response_err <= 1'b0;
    end else if (req) begin
        avs_response_err <= !(sel_c1 || sel_c2 || sel_st);
        if (sel_c2)
            avs_readdata <= {16'h0000, converter_control_two};
        else if (sel_c1)
            avs_readdata <= {16'h0000, converter_control_one};
        else if (sel_st)
            avs_readdata <= {28'h0000000, conv_b_end_irq, conv_a_end_irq,
                             b_busy, a_busy};
        else
            avs_readdata <= 32'h0000_0000;
    end
end

endmodule // apsc_scan_ctrl
